// [common/dprc_regs.vh]
// Register map and timing constants for the downstream port reset controller.
// Assumes a 32-bit APB slave with byte addresses and one word per register.
`ifndef DPRC_REGS_VH
`define DPRC_REGS_VH

// Byte offsets
`define DPRC_OFF_SWITCH_CONTROL_REG       12'h000
`define DPRC_OFF_UP_BRIDGE   12'h004
`define DPRC_OFF_DN_BRIDGE   12'h008
`define DPRC_OFF_SLOT_CTRL   12'h00c
`define DPRC_OFF_HP_CFG      12'h010
`define DPRC_OFF_STATUS      12'h014
`define DPRC_OFF_PIN_FUNC    12'h018
`define DPRC_OFF_TICK        12'h01c
`define DPRC_OFF_DN_SCRATCH  12'h020

// Field positions
`define DPRC_SWITCH_CONTROL_REG_HOT_RESET_BIT 0
`define DPRC_MODE_LSB            0
`define DPRC_POWER_TO_RESET_DELAY_LSB         8
`define DPRC_RESET_TO_POWER_DELAY_LSB         16
`define DPRC_DELAY_W             8

// Reset values
`define DPRC_HP_CFG_RESET    32'h0000_0000
`define DPRC_TICK_RESET      16'h00f9
`define DPRC_SCRATCH_RESET   32'h0000_0000

// Reset output modes
`define DPRC_MODE_PWR_EN     2'h0
`define DPRC_MODE_PWR_GOOD   2'h1
`define DPRC_MODE_HOT_RESET  2'h2

// Timing
`define DPRC_CLK_MHZ         250
`define DPRC_MIN_PULSE_US    200
`define DPRC_MIN_PULSE_CYC   (`DPRC_MIN_PULSE_US * `DPRC_CLK_MHZ)

`endif

// [logic/dprc_reset_ctrl.v]
// Downstream port reset controller: secondary bus resets and per-port reset outputs.
// Assumes APB from the host on i_core_clk; slot power good and link state are
// asynchronous and are synchronised here.
// Operation
// (R1) Upstream bridge reset bit starts upstream reset
// (R2) Linked-up downstream ports send hot-reset TS1
// (R3) Upstream reset restores non-sticky downstream fields
// (R4) Drop downstream queues, reset downstream logic
// (R5) Hold downstream ports until bit clears
// (R6) Upstream link and Type 0 config unaffected
// (R7) Upstream secondary-side packets become unsupported
// (R8) SMBus reads default, writes discarded during reset
// (R9) Downstream reset: TS1, drop, wait, resume
// (R10) Other ports run; reset port gets unsupported
// (R11) Reset outputs undriven until pin function set
// (R12) Reset output asserts at least 200 us
// (R13) Mode field selects reset output behaviour
// (R14) Power-enable mode: reset follows slot power
// (R15) Power on: enable, then delayed reset negate
// (R16) Power off: reset first, then delayed disable
// (R17) Power-good mode: negate after good plus delay
// (R18) Power-good loss asserts reset at once
// (R19) Hot-reset mode: hot or bus resets assert
// (R20) Hot-reset hold: longer of cause, 200 us
// (R21) Hot reset bit raises switch hot reset
// (R22) Own mode encoding and tick unit delays
`timescale 1ns/10ps
`include "dprc_regs.vh"

module dprc_reset_ctrl #(
  parameter NPORTS    = 4,
  parameter MIN_PULSE = `DPRC_MIN_PULSE_CYC
) (
  input  wire              i_core_clk,
  input  wire              i_rst_n,
  input  wire              i_psel,
  input  wire              i_penable,
  input  wire              i_pwrite,
  input  wire [11:0]       i_paddr,
  input  wire [31:0]       i_pwdata,
  output wire              o_pready,
  output reg  [31:0]       o_prdata,
  output wire              o_pslverr,
  input  wire              i_smb_sel,
  input  wire              i_smb_write,
  input  wire [11:0]       i_smb_addr,
  input  wire [31:0]       i_smb_wdata,
  output reg  [31:0]       o_smb_rdata,
  input  wire              i_ext_hot_reset,
  input  wire [NPORTS-1:0] i_link_up,
  input  wire [NPORTS-1:0] i_slot_power_good_n,
  output reg  [NPORTS-1:0] o_port_reset_out_n,
  output reg  [NPORTS-1:0] o_port_reset_oe_n,
  output reg  [NPORTS-1:0] o_slot_power_enable_out,
  output reg  [NPORTS-1:0] o_send_hot_reset_ts1,
  output reg  [NPORTS-1:0] o_drop_queued,
  output reg  [NPORTS-1:0] o_port_logic_reset,
  output reg  [NPORTS-1:0] o_secondary_ur,
  output reg               o_switch_hot_reset
);

  localparam ST_OFF    = 2'h0;
  localparam ST_PWRUP  = 2'h1;
  localparam ST_ON     = 2'h2;
  localparam ST_PWRDN  = 2'h3;
  localparam PW        = 24;

  reg  [NPORTS-1:0] pg_meta;
  reg  [NPORTS-1:0] pg_n;
  reg  [NPORTS-1:0] lu_meta;
  reg  [NPORTS-1:0] link_up;
  reg               up_sbr;
  reg  [NPORTS-1:0] dn_sbr;
  reg  [NPORTS-1:0] power_off_ctl;
  reg  [NPORTS-1:0] pin_func;
  reg  [31:0]       hp_cfg;
  reg  [15:0]       tick_div;
  reg  [31:0]       dn_scratch;
  reg               hot_pend;
  reg               hot_done;
  reg  [15:0]       tick_cnt;
  reg               tick;
  reg  [1:0]        pst [0:NPORTS-1];
  reg  [7:0]        dly [0:NPORTS-1];
  reg  [PW-1:0]     pulse [0:NPORTS-1];
  reg  [NPORTS-1:0] rst_asrt;
  reg  [NPORTS-1:0] next_rst_asrt;
  reg  [NPORTS-1:0] hot_cause;
  reg  [31:0]       status_word;
  reg  [NPORTS-1:0] next_pwr_en;
  integer           p;
  integer           q;

  wire [1:0] mode    = hp_cfg[`DPRC_MODE_LSB +: 2];
  wire [7:0] power_to_reset_delay = hp_cfg[`DPRC_POWER_TO_RESET_DELAY_LSB +: `DPRC_DELAY_W];
  wire [7:0] reset_to_power_delay = hp_cfg[`DPRC_RESET_TO_POWER_DELAY_LSB +: `DPRC_DELAY_W];
  wire       apb_wr  = i_psel & i_penable & i_pwrite;
  wire       hot_any = o_switch_hot_reset | i_ext_hot_reset;

  // (R6) Config accesses always complete, zero wait
  assign o_pready  = 1'b1;
  assign o_pslverr = 1'b0;

  always @(posedge i_core_clk) begin
    pg_meta <= i_slot_power_good_n;
    pg_n    <= pg_meta;
    lu_meta <= i_link_up;
    link_up <= lu_meta;
  end

  always @* begin
    status_word = 32'h0000_0000;
    status_word[NPORTS-1:0]        = ~rst_asrt;
    status_word[8 +: NPORTS]       = o_slot_power_enable_out;
    status_word[16 +: NPORTS]      = ~pg_n;
    status_word[24 +: NPORTS]      = link_up;
  end

  always @* begin
    case (i_paddr)
      `DPRC_OFF_SWITCH_CONTROL_REG:      o_prdata = {31'h0, hot_pend | o_switch_hot_reset};
      `DPRC_OFF_UP_BRIDGE:  o_prdata = {31'h0, up_sbr};
      `DPRC_OFF_DN_BRIDGE:  o_prdata = {{(32-NPORTS){1'b0}}, dn_sbr};
      `DPRC_OFF_SLOT_CTRL:  o_prdata = {{(32-NPORTS){1'b0}}, power_off_ctl};
      `DPRC_OFF_HP_CFG:     o_prdata = hp_cfg;
      `DPRC_OFF_STATUS:     o_prdata = status_word;
      `DPRC_OFF_PIN_FUNC:   o_prdata = {{(32-NPORTS){1'b0}}, pin_func};
      `DPRC_OFF_TICK:       o_prdata = {16'h0, tick_div};
      `DPRC_OFF_DN_SCRATCH: o_prdata = dn_scratch;
      default:              o_prdata = 32'h0000_0000;
    endcase
  end

  // (R8) Default value while downstream registers are reset
  always @* begin
    if (i_smb_addr == `DPRC_OFF_DN_SCRATCH) begin
      o_smb_rdata = up_sbr ? `DPRC_SCRATCH_RESET : dn_scratch;
    end else begin
      o_smb_rdata = (i_smb_addr == `DPRC_OFF_HP_CFG) ? hp_cfg : 32'h0000_0000;
    end
  end

  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      up_sbr        <= 1'b0;
      dn_sbr        <= {NPORTS{1'b0}};
      power_off_ctl <= {NPORTS{1'b1}};
      pin_func      <= {NPORTS{1'b0}};
      hp_cfg        <= `DPRC_HP_CFG_RESET;
      tick_div      <= `DPRC_TICK_RESET;
      dn_scratch    <= `DPRC_SCRATCH_RESET;
      hot_pend      <= 1'b0;
    end else begin
      // (R21) Hot reset after the completion
      if (apb_wr && i_paddr == `DPRC_OFF_SWITCH_CONTROL_REG && i_pwdata[`DPRC_SWITCH_CONTROL_REG_HOT_RESET_BIT]) begin
        hot_pend <= 1'b1;
      end else if (hot_done) begin
        hot_pend <= 1'b0;
      end
      // (R1) Upstream bridge reset bit
      if (apb_wr && i_paddr == `DPRC_OFF_UP_BRIDGE) begin
        up_sbr <= i_pwdata[0];
      end
      // (R9) Per-port bridge reset bit
      if (apb_wr && i_paddr == `DPRC_OFF_DN_BRIDGE) begin
        dn_sbr <= i_pwdata[NPORTS-1:0];
      end
      if (apb_wr && i_paddr == `DPRC_OFF_SLOT_CTRL) begin
        power_off_ctl <= i_pwdata[NPORTS-1:0];
      end
      // (R13) Mode and delay fields
      if (apb_wr && i_paddr == `DPRC_OFF_HP_CFG) begin
        hp_cfg <= i_pwdata;
      end
      if (apb_wr && i_paddr == `DPRC_OFF_PIN_FUNC) begin
        pin_func <= i_pwdata[NPORTS-1:0];
      end
      if (apb_wr && i_paddr == `DPRC_OFF_TICK) begin
        tick_div <= i_pwdata[15:0];
      end
      // (R3) Non-sticky downstream field restored; (R8) SMBus write dropped
      if (up_sbr) begin
        dn_scratch <= `DPRC_SCRATCH_RESET;
      end else if (apb_wr && i_paddr == `DPRC_OFF_DN_SCRATCH) begin
        dn_scratch <= i_pwdata;
      end else if (i_smb_sel && i_smb_write && i_smb_addr == `DPRC_OFF_DN_SCRATCH) begin
        dn_scratch <= i_smb_wdata;
      end
    end
  end

  // One pulse per request; hot_done blocks a repeat before pend clears
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_switch_hot_reset <= 1'b0;
      hot_done           <= 1'b0;
    end else begin
      o_switch_hot_reset <= hot_pend & ~o_switch_hot_reset & ~hot_done;
      hot_done           <= o_switch_hot_reset;
    end
  end

  // (R22) Delay tick, one pulse every tick_div+1 cycles
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else if (tick_cnt >= tick_div) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  // (R2) (R4) (R5) (R7) (R9) (R10) Per-port secondary reset actions
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_send_hot_reset_ts1 <= {NPORTS{1'b0}};
      o_drop_queued        <= {NPORTS{1'b0}};
      o_port_logic_reset   <= {NPORTS{1'b0}};
      o_secondary_ur       <= {NPORTS{1'b0}};
    end else begin
      o_send_hot_reset_ts1 <= ({NPORTS{up_sbr}} | dn_sbr) & link_up;
      o_drop_queued        <= {NPORTS{up_sbr}} | dn_sbr;
      o_port_logic_reset   <= {NPORTS{up_sbr}};
      o_secondary_ur       <= {NPORTS{up_sbr}} | dn_sbr;
    end
  end

  // (R19) Causes of a hot-reset mode assertion
  always @* begin
    hot_cause = {NPORTS{hot_any | up_sbr}} | dn_sbr;
  end

  // Slot power sequencing per port
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      for (p = 0; p < NPORTS; p = p + 1) begin
        pst[p]   <= ST_OFF;
        dly[p]   <= 8'h00;
        // (R12) Reset-time assertion also counts
        pulse[p] <= MIN_PULSE[PW-1:0];
      end
      rst_asrt                <= {NPORTS{1'b1}};
      o_slot_power_enable_out <= {NPORTS{1'b0}};
    end else begin
      rst_asrt                <= next_rst_asrt;
      o_slot_power_enable_out <= next_pwr_en;
      for (p = 0; p < NPORTS; p = p + 1) begin
        // (R12) Minimum pulse counter
        if (next_rst_asrt[p] && !rst_asrt[p]) begin
          pulse[p] <= MIN_PULSE[PW-1:0];
        end else if (pulse[p] != {PW{1'b0}}) begin
          pulse[p] <= pulse[p] - {{(PW-1){1'b0}}, 1'b1};
        end
        case (pst[p])
          ST_OFF: begin
            // (R15) Power enable then delay
            if (!power_off_ctl[p]) begin
              pst[p] <= ST_PWRUP;
              dly[p] <= power_to_reset_delay;
            end
          end
          ST_PWRUP: begin
            if (power_off_ctl[p]) begin
              pst[p] <= ST_PWRDN;
              dly[p] <= reset_to_power_delay;
            end else if (mode == `DPRC_MODE_PWR_GOOD && pg_n[p]) begin
              // (R17) Count only from power good
              dly[p] <= power_to_reset_delay;
            end else if (dly[p] == 8'h00) begin
              pst[p] <= ST_ON;
            end else if (tick) begin
              dly[p] <= dly[p] - 8'h01;
            end
          end
          ST_ON: begin
            // (R16) Reset first, then delayed disable
            if (power_off_ctl[p]) begin
              pst[p] <= ST_PWRDN;
              dly[p] <= reset_to_power_delay;
            end
          end
          ST_PWRDN: begin
            if (dly[p] == 8'h00) begin
              pst[p] <= ST_OFF;
            end else if (tick) begin
              dly[p] <= dly[p] - 8'h01;
            end
          end
          default: begin
            pst[p] <= ST_OFF;
          end
        endcase
      end
    end
  end

  always @* begin
    for (q = 0; q < NPORTS; q = q + 1) begin
      next_pwr_en[q] = (pst[q] != ST_OFF);
      case (mode)
        // (R14) Reset follows slot power state
        `DPRC_MODE_PWR_EN:
          next_rst_asrt[q] = (pst[q] != ST_ON);
        // (R18) Power good loss asserts at once
        `DPRC_MODE_PWR_GOOD:
          next_rst_asrt[q] = (pst[q] != ST_ON) | pg_n[q];
        // (R20) Longer of cause and minimum pulse
        `DPRC_MODE_HOT_RESET:
          next_rst_asrt[q] = hot_cause[q];
        default:
          next_rst_asrt[q] = 1'b1;
      endcase
      // (R12) Stretch every assertion
      if (rst_asrt[q] && pulse[q] != {PW{1'b0}}) begin
        next_rst_asrt[q] = 1'b1;
      end
    end
  end

  // (R11) Driven only when pin function selected
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_port_reset_out_n <= {NPORTS{1'b1}};
      o_port_reset_oe_n  <= {NPORTS{1'b1}};
    end else begin
      o_port_reset_out_n <= ~rst_asrt;
      o_port_reset_oe_n  <= ~pin_func;
    end
  end

  // (R6) Upstream side has no hook here; link and config untouched

endmodule

// [verif/dprc_reset_ctrl_props.sv]
// Checker on the reset controller ports.
// Bound to every dprc_reset_ctrl; sees only its top-level ports.
`timescale 1ns/10ps
module dprc_reset_ctrl_props #(
  parameter NPORTS    = 4,
  parameter MIN_PULSE = 50000
) (
  input wire logic              i_core_clk,
  input wire logic              i_rst_n,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [11:0]       i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic              o_pslverr,
  input wire logic [NPORTS-1:0] o_port_reset_out_n,
  input wire logic [NPORTS-1:0] o_port_reset_oe_n,
  input wire logic [NPORTS-1:0] o_slot_power_enable_out,
  input wire logic [NPORTS-1:0] o_drop_queued,
  input wire logic [NPORTS-1:0] o_secondary_ur,
  input wire logic [NPORTS-1:0] o_port_logic_reset,
  input wire logic              o_switch_hot_reset
);
  logic [15:0] lo_cnt;
  wire         acc = i_psel && i_penable && i_pwrite;
  wire [NPORTS-1:0] up_all = o_drop_queued & o_secondary_ur & o_port_logic_reset;
  // Saturates so a long hold cannot wrap into a short one
  always @(posedge i_core_clk) begin
    if (!i_rst_n || o_port_reset_out_n[0])
      lo_cnt <= 16'h0000;
    else if (lo_cnt != 16'hffff)
      lo_cnt <= lo_cnt + 16'h0001;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  property p_oe; $rose(i_rst_n) |-> &o_port_reset_oe_n && o_slot_power_enable_out == '0; endproperty
  a_oe: assert property (p_oe) else $error("reset pin driven out of reset");
  property p_min; $rose(o_port_reset_out_n[0]) |-> lo_cnt >= MIN_PULSE; endproperty
  a_min: assert property (p_min) else $error("reset pulse too short");
  property p_hot; acc && i_paddr == 12'h000 && i_pwdata[0] |-> ##[1:3] o_switch_hot_reset; endproperty
  a_hot: assert property (p_hot) else $error("no hot reset pulse");
  property p_hot1; o_switch_hot_reset |=> !o_switch_hot_reset; endproperty
  a_hot1: assert property (p_hot1) else $error("hot reset pulse too long");
  property p_up; acc && i_paddr == 12'h004 && i_pwdata[0] |-> ##[1:3] &up_all; endproperty
  a_up: assert property (p_up) else $error("bus reset actions missing");
  property p_off; $fell(o_slot_power_enable_out[0]) |-> !o_port_reset_out_n[0]; endproperty
  a_off: assert property (p_off) else $error("power dropped before reset");
  property p_on; $rose(o_port_reset_out_n[0]) |-> o_slot_power_enable_out[0]; endproperty
  a_on: assert property (p_on) else $error("reset released without power");
  property p_ron; $rose(o_slot_power_enable_out[0]) |-> !o_port_reset_out_n[0]; endproperty
  a_ron: assert property (p_ron) else $error("reset not held at power on");
  property p_err; o_pslverr == 1'b0; endproperty
  a_err: assert property (p_err) else $error("slave error raised");
endmodule

bind dprc_reset_ctrl dprc_reset_ctrl_props #(.NPORTS(NPORTS), .MIN_PULSE(MIN_PULSE)) i_props (
  .i_core_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pslverr,
  .o_port_reset_out_n, .o_port_reset_oe_n, .o_slot_power_enable_out, .o_drop_queued,
  .o_secondary_ur, .o_port_logic_reset, .o_switch_hot_reset);

// [verif/dprc_reset_ctrl_tb.sv]
// Self-checking bench for the downstream port reset controller.
// Drives APB and the SMBus side; slot model closes the power loop.
`timescale 1ns/10ps
`include "dprc_regs.vh"
module dprc_reset_ctrl_tb;
  localparam MP = 20;
  localparam [11:0] HP = `DPRC_OFF_HP_CFG, SC = `DPRC_OFF_SLOT_CTRL, SR = `DPRC_OFF_DN_SCRATCH;
  logic        i_core_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic        i_smb_sel = 0, i_smb_write = 0, i_ext_hot_reset = 0;
  logic [11:0] i_paddr = 0, i_smb_addr = 0;
  logic [31:0] i_pwdata = 0, i_smb_wdata = 0, rd;
  logic [3:0]  flt = 0;
  wire         o_pready, o_pslverr, o_switch_hot_reset;
  wire  [31:0] o_prdata, o_smb_rdata;
  wire  [3:0]  i_link_up, i_slot_power_good_n, o_port_reset_out_n, o_port_reset_oe_n, o_slot_power_enable_out;
  wire  [3:0]  o_send_hot_reset_ts1, o_drop_queued, o_port_logic_reset, o_secondary_ur;
  int          error_cnt = 0, num_checks = 0, n;

  dprc_reset_ctrl #(.NPORTS(4), .MIN_PULSE(MP)) i_dprc_reset_ctrl (.i_core_clk, .i_rst_n, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_smb_sel,
    .i_smb_write, .i_smb_addr, .i_smb_wdata, .o_smb_rdata, .i_ext_hot_reset, .i_link_up,
    .i_slot_power_good_n, .o_port_reset_out_n, .o_port_reset_oe_n, .o_slot_power_enable_out,
    .o_send_hot_reset_ts1, .o_drop_queued, .o_port_logic_reset, .o_secondary_ur, .o_switch_hot_reset);
  dprc_slot_model #(.PGD(6)) i_dprc_slot_model (.i_core_clk, .i_pwr_en(o_slot_power_enable_out),
    .i_fault(flt), .o_pg_n(i_slot_power_good_n), .o_link_up(i_link_up));

  initial forever #2 i_core_clk = ~i_core_clk;

  task conclude;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin error_cnt++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end
  endtask
  task chkr(input int g, lo, hi);
    num_checks++;
    if (g < lo || g > hi) begin error_cnt++; $display("unexpected at %0t: got %h exp %h..%h", $time, g, lo, hi); end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    i_psel <= 1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
    @(posedge i_core_clk); i_penable <= 1;
    do begin @(posedge i_core_clk); k++; end while (o_pready !== 1'b1 && k < 50);
    rd = o_prdata;
    if (k >= 50) begin error_cnt++; conclude; end
    i_psel <= 0; i_penable <= 0;
    @(posedge i_core_clk);
  endtask
  task smb(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_smb_sel <= w; i_smb_write <= w; i_smb_addr <= a; i_smb_wdata <= d;
    @(posedge i_core_clk); i_smb_sel <= 0; i_smb_write <= 0; rd = o_smb_rdata;
    @(posedge i_core_clk);
  endtask
  function logic sg(int s, p);
    case (s)
      0: return o_port_reset_out_n[p];
      1: return o_slot_power_enable_out[p];
      default: return o_switch_hot_reset;
    endcase
  endfunction
  task wt(input int s, p, input logic v);
    n = 0;
    while (sg(s, p) !== v) begin
      @(posedge i_core_clk); n++;
      if (n > 3000) begin error_cnt++; conclude; end
    end
  endtask

  task t_pwr;
    chk(o_port_reset_oe_n, 4'hf);
    apb(0, 12'h100, 0); chk(rd, 0);
    apb(1, `DPRC_OFF_TICK, 0); apb(1, HP, 32'h0006_0800); apb(1, `DPRC_OFF_PIN_FUNC, 32'hf);
    // Pin enable is registered one edge after the write
    @(posedge i_core_clk);
    chk(o_port_reset_oe_n, 4'h0); chk(o_port_reset_out_n, 4'h0);
    apb(1, SC, 32'he); wt(1, 0, 1); wt(0, 0, 1); chkr(n, 8, 11);
    chk(o_port_reset_out_n, 4'h1);
    apb(1, SC, 32'hf); wt(0, 0, 0); wt(1, 0, 0); chkr(n, 6, 9);
    $display("power enable mode done");
  endtask
  task t_pg;
    apb(1, HP, 32'h0006_0801); apb(1, SC, 32'he); wt(1, 0, 1); wt(0, 0, 1); chkr(n, 14, 20);
    // Two synchroniser flops plus two register stages
    flt <= 4'h1; wt(0, 0, 0); chkr(n, 4, 5);
    flt <= 4'h0; apb(1, SC, 32'h0); wt(0, 3, 1);
    $display("power good mode done");
  endtask
  task t_up;
    apb(1, HP, 32'h0006_0802); smb(1, SR, 32'h5a5); smb(0, SR, 0); chk(rd, 32'h5a5);
    apb(1, `DPRC_OFF_UP_BRIDGE, 1); repeat (4) @(posedge i_core_clk);
    chk(o_drop_queued, 4'hf); chk(o_port_logic_reset, 4'hf);
    chk(o_secondary_ur, 4'hf); chk(o_send_hot_reset_ts1, 4'hf);
    chk(o_port_reset_out_n, 4'h0);
    smb(1, SR, 32'h3); smb(0, SR, 0); chk(rd, 0);
    apb(0, HP, 0); chk(rd, 32'h0006_0802);
    repeat (30) @(posedge i_core_clk);
    apb(1, `DPRC_OFF_UP_BRIDGE, 0); wt(0, 0, 1); chkr(n, 0, 3);
    chk(o_drop_queued, 4'h0);
    smb(0, SR, 0); chk(rd, 0);
    $display("upstream bus reset done");
  endtask
  task t_dn;
    apb(1, `DPRC_OFF_DN_BRIDGE, 2); repeat (3) @(posedge i_core_clk);
    chk(o_drop_queued, 4'h2); chk(o_send_hot_reset_ts1, 4'h2);
    chk(o_secondary_ur, 4'h2); chk(o_port_reset_out_n, 4'hd);
    apb(1, `DPRC_OFF_DN_BRIDGE, 0); wt(0, 1, 1); chkr(n, MP - 10, MP + 2);
    $display("downstream bus reset done");
  endtask
  task t_hot;
    apb(1, `DPRC_OFF_SWITCH_CONTROL_REG, 1); wt(2, 0, 1); chkr(n, 0, 3);
    repeat (2) @(posedge i_core_clk); chk(o_port_reset_out_n, 4'h0);
    // One-cycle cause, so the minimum pulse decides
    wt(0, 0, 1); chkr(n, MP - 2, MP + 2);
    i_ext_hot_reset <= 1; repeat (3) @(posedge i_core_clk);
    chk(o_port_reset_out_n, 4'h0);
    repeat (30) @(posedge i_core_clk); i_ext_hot_reset <= 0;
    wt(0, 0, 1); chkr(n, 0, 3);
    // Mode 3 holds every reset output asserted
    apb(1, HP, 32'h0006_0803); repeat (2) @(posedge i_core_clk);
    chk(o_port_reset_out_n, 4'h0);
    $display("hot reset done");
  endtask

  initial begin
    repeat (16) @(posedge i_core_clk);
    i_rst_n <= 1;
    repeat (2) @(posedge i_core_clk);
    t_pwr;
    t_pg;
    t_up;
    t_dn;
    t_hot;
    conclude;
  end
endmodule

// [verif/dprc_slot_model.sv]
// Slot power supply and link partner for four downstream slots.
// Power good follows enable after PGD cycles; the bench may inject faults.
`timescale 1ns/10ps
module dprc_slot_model #(
  parameter PGD = 6
) (
  input  wire logic       i_core_clk,
  input  wire logic [3:0] i_pwr_en,
  input  wire logic [3:0] i_fault,
  output logic      [3:0] o_pg_n,
  output logic      [3:0] o_link_up
);
  logic [7:0] cnt [4] = '{default: 8'h00};
  always @(posedge i_core_clk) begin
    for (int i = 0; i < 4; i++)
      if (!i_pwr_en[i]) cnt[i] <= 8'h00;
      else if (cnt[i] != PGD) cnt[i] <= cnt[i] + 8'h01;
  end
  // Link only trains once the supply is good
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      o_pg_n[i]    = i_fault[i] | (cnt[i] != PGD);
      o_link_up[i] = !o_pg_n[i];
    end
  end
endmodule
